// >>> tbio_defines.svh
// How it works
// - each direct output sends its selected operand
// - sixteen teleprotection inputs on channel one
// - channel two inputs only in two-channel mode or three-terminal systems
// - teleprotection inputs usable only when enabled
// - failed channel, forced-high gives logic one
// - failed channel, forced-low gives logic zero
// - hold choices freeze last received value
// - unknown last value: hold-high one, hold-low zero
// - three-terminal permission is AND of both remotes
// - direct input may source a direct output
// - direct input picks bit from chosen source
// - restored link resumes tracking once link-up reaches sync flops 1 and 2
`ifndef TBIO_DEFINES_SVH
`define TBIO_DEFINES_SVH
`define TBIO_DIR_OUTS 32
`define TBIO_DIR_INS 32
`define TBIO_TELE_BITS 16
`define TBIO_OPERANDS 64
`define TBIO_SEL_W 7
`define TBIO_SOURCES 4
`define TBIO_SRC_W 2
`define TBIO_BIT_W 5
`define TBIO_FB_FORCE_HIGH 2'h0
`define TBIO_FB_FORCE_LOW 2'h1
`define TBIO_FB_HOLD_HIGH 2'h2
`define TBIO_FB_HOLD_LOW 2'h3
`define TBIO_SYNC_RESET 3'h0
`endif

// >>> tbio_pkg.sv
package tbio_pkg;
    typedef logic [1:0] tbio_fallback_t;
    typedef struct packed {
        logic [15:0] bits;
        logic linkUp;
    } tbio_chan_s;
    typedef struct packed {
        logic [15:0] value;
        logic [15:0] known;
        logic [2:0] linkSync;
    } tbio_hold_s;
    typedef struct packed {
        tbio_hold_s ch1;
        tbio_hold_s ch2;
        logic [31:0] dirValue;
        logic [31:0] dirKnown;
        logic [31:0] dirOut;
        logic [3:0][2:0] srcSync;
    } tbio_state_s;
endpackage

// >>> tbio_teleprotection_bit_io.sv
`timescale 1ns/10ps
`default_nettype none
`include "tbio_defines.svh"
module tbio_teleprotection_bit_io
    import tbio_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic teleEnable,
    input wire logic twoChannelMode,
    input wire logic threeTerminal,
    input wire tbio_chan_s chan1Rx,
    input wire tbio_chan_s chan2Rx,
    input wire logic [31:0] tele_input_fallback_select,
    input wire logic [31:0] tele_input_fallback_select_ch2,
    input wire logic [31:0] localOperands,
    input wire logic [31:0][6:0] directOutSelect,
    input wire logic [3:0][31:0] directRxStream,
    input wire logic [3:0] directSourceUp,
    input wire logic [31:0][1:0] direct_input_source_id,
    input wire logic [31:0][4:0] directInputBitNum,
    input wire logic [31:0][1:0] directInputFallback,
    input wire logic [15:0] hybrid_permissive_send_ch1,
    input wire logic [15:0] hybrid_permissive_send_ch2,
    output logic [15:0] teleIn1,
    output logic [15:0] teleIn2,
    output logic [15:0] hybrid_permissive_receive,
    output logic [31:0] directIn,
    output logic [31:0] directOut
);
    tbio_state_s state_q;
    tbio_state_s state_d;
    logic [15:0] tele1;
    logic [15:0] tele2;
    logic [31:0] dirEff;
    logic [63:0] operandPool;

    // resolved fallback value for one bit; decode shared by every input
    function automatic logic fallbackBit(input logic [1:0] sel, input logic val, input logic known);
        logic r;
        r = 1'b0;
        case (sel)
            // forced high
            // force logic one
            `TBIO_FB_FORCE_HIGH: r = 1'b1;
            `TBIO_FB_FORCE_LOW: r = 1'b0;
            `TBIO_FB_HOLD_HIGH: r = known ? val : 1'b1;
            `TBIO_FB_HOLD_LOW: r = known ? val : 1'b0;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // link-up levels come from the channel logic, another timing world: three flops
    function automatic logic linkGood(input logic [2:0] s);
        return s[1] & s[2];
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        state_d = state_q;
        state_d.ch1.linkSync = {state_q.ch1.linkSync[1:0], chan1Rx.linkUp};
        state_d.ch2.linkSync = {state_q.ch2.linkSync[1:0], chan2Rx.linkUp};
        for (int s = 0; s < `TBIO_SOURCES; s++)
        begin
            state_d.srcSync[s] = {state_q.srcSync[s][1:0], directSourceUp[s]};
        end
        if (linkGood(state_q.ch1.linkSync))
        begin
            state_d.ch1.value = chan1Rx.bits;
            state_d.ch1.known = 16'hFFFF;
        end
        if (linkGood(state_q.ch2.linkSync))
        begin
            state_d.ch2.value = chan2Rx.bits;
            state_d.ch2.known = 16'hFFFF;
        end
        for (int i = 0; i < `TBIO_DIR_INS; i++)
        begin
            if (linkGood(state_q.srcSync[direct_input_source_id[i]]))
            begin
                state_d.dirValue[i] = directRxStream[direct_input_source_id[i]][directInputBitNum[i]];
                state_d.dirKnown[i] = 1'b1;
            end
        end
        for (int o = 0; o < `TBIO_DIR_OUTS; o++)
        begin
            state_d.dirOut[o] = operandPool[directOutSelect[o][5:0]];
        end
        if (!reset_n)
        begin
            state_d = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        state_q <= state_d;
    end

    // ----------------------------------------
    // fallback resolution
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < `TBIO_TELE_BITS; g++)
        begin : gTele
            assign tele1[g] = linkGood(state_q.ch1.linkSync) ? state_q.ch1.value[g] :
                fallbackBit(tele_input_fallback_select[2*g +: 2], state_q.ch1.value[g], state_q.ch1.known[g]);
            assign tele2[g] = linkGood(state_q.ch2.linkSync) ? state_q.ch2.value[g] :
                fallbackBit(tele_input_fallback_select_ch2[2*g +: 2], state_q.ch2.value[g], state_q.ch2.known[g]);
        end
        for (g = 0; g < `TBIO_DIR_INS; g++)
        begin : gDir
            assign dirEff[g] = linkGood(state_q.srcSync[direct_input_source_id[g]]) ? state_q.dirValue[g] :
                fallbackBit(directInputFallback[g], state_q.dirValue[g], state_q.dirKnown[g]);
        end
    endgenerate

    assign operandPool = {dirEff, localOperands};

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // channel one inputs
    assign teleIn1 = teleEnable ? tele1 : 16'h0000;
    assign teleIn2 = (teleEnable && (twoChannelMode || threeTerminal)) ? tele2 : 16'h0000;
    assign hybrid_permissive_receive = threeTerminal ? (teleIn1 & teleIn2) : teleIn1;
    assign directIn = dirEff;
    assign directOut = state_q.dirOut;
endmodule
`default_nettype wire

// >>> tbio_remote_relay.sv
`timescale 1ns/10ps
`default_nettype none
module tbio_remote_relay
    import tbio_pkg::*;
(
    input wire logic clk,
    input wire logic linkOk,
    input wire logic [15:0] assigned,
    output var tbio_chan_s rx
);
    logic [3:0] upQ;
    // bits stay valid four cycles past a drop, then toggle as garbage
    always_ff @(posedge clk)
    begin
        upQ <= {upQ[2:0], linkOk};
        rx.linkUp <= linkOk;
        rx.bits <= (linkOk || upQ[3]) ? assigned : ~rx.bits;
    end
endmodule
`default_nettype wire

// >>> tbio_teleprotection_bit_io_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module tbio_chk
    import tbio_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic teleEnable,
    input wire logic threeTerminal,
    input wire tbio_chan_s chan1Rx,
    input wire logic [31:0] tele_input_fallback_select,
    input wire logic [31:0] localOperands,
    input wire logic [31:0][6:0] directOutSelect,
    input wire logic [15:0] teleIn1,
    input wire logic [15:0] teleIn2,
    input wire logic [15:0] hybrid_permissive_receive,
    input wire logic [31:0] directOut
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    wire logic [1:0] fb = tele_input_fallback_select[1:0];
    property p_and; threeTerminal |-> hybrid_permissive_receive == (teleIn1 & teleIn2); endproperty
    a_and: assert property (p_and) else $error("and");
    property p_one; !threeTerminal |-> hybrid_permissive_receive == teleIn1; endproperty
    a_one: assert property (p_one) else $error("one");
    property p_off; !teleEnable |-> (teleIn1 | teleIn2) == 16'h0; endproperty
    a_off: assert property (p_off) else $error("off");
    property p_hi; (!chan1Rx.linkUp)[*5] ##0 teleEnable && fb == 2'h0 && $stable(fb) |-> teleIn1[0]; endproperty
    a_hi: assert property (p_hi) else $error("hi");
    property p_lo; (!chan1Rx.linkUp)[*5] ##0 teleEnable && fb == 2'h1 && $stable(fb) |-> !teleIn1[0]; endproperty
    a_lo: assert property (p_lo) else $error("lo");
    property p_hold; (!chan1Rx.linkUp)[*5] ##0 teleEnable && $stable(teleEnable) && fb[1] && $stable(fb)
        |-> $stable(teleIn1[0]); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_trk; chan1Rx.linkUp[*6] ##0 teleEnable && $stable(chan1Rx.bits) |-> teleIn1 == chan1Rx.bits; endproperty
    a_trk: assert property (p_trk) else $error("trk");
    property p_dout; $past(reset_n) && !$past(directOutSelect[0][5])
        |-> directOut[0] == $past(localOperands[directOutSelect[0][4:0]]); endproperty
    a_dout: assert property (p_dout) else $error("dout");
endmodule
bind tbio_teleprotection_bit_io tbio_chk chk (.*);
`default_nettype wire

// >>> tbio_teleprotection_bit_io_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tbio_teleprotection_bit_io_tb;
    import tbio_pkg::*;
    logic clk = 0, reset_n = 0, teleEnable = 1, threeTerminal = 0, link = 0, twoChan = 1;
    logic [31:0] fbSel = '0, localOperands = '0, directIn, directOut;
    logic [31:0][6:0] directOutSelect;
    logic [15:0] teleIn1, teleIn2, hybrid_permissive_receive;
    tbio_chan_s chan1Rx, chan2Rx;
    int errors = 0, checks_done = 0;
    tbio_remote_relay r1 (.clk, .linkOk(link), .assigned(localOperands[15:0]), .rx(chan1Rx));
    tbio_remote_relay r2 (.clk, .linkOk(link), .assigned(localOperands[15:0] ^ 16'h00FF), .rx(chan2Rx));
    tbio_teleprotection_bit_io uut (.*, .twoChannelMode(twoChan), .tele_input_fallback_select(fbSel),
        .tele_input_fallback_select_ch2(fbSel), .directRxStream({4{localOperands}}), .directSourceUp({4{link}}),
        .direct_input_source_id('0), .directInputBitNum({32{5'h01}}), .directInputFallback('0),
        .hybrid_permissive_send_ch1('0), .hybrid_permissive_send_ch2('0));
    initial forever #5 clk = ~clk;
    task step(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task test_done;
        if (errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task t_fall;
        for (int f = 0; f < 4; f++)
        begin
            @(posedge clk);
            fbSel <= {16{2'(f)}};
            step(2);
            chk(32'(teleIn1), f[0] ? 32'h0 : 32'hFFFF);
        end
    endtask
    task t_track;
        @(posedge clk);
        fbSel <= {16{2'h3}};
        threeTerminal <= 1;
        localOperands <= 32'hA5C3;
        link <= 1;
        step(8);
        chk(32'(teleIn1), 32'hA5C3);
        chk(32'(hybrid_permissive_receive), 32'hA500);
        @(posedge clk);
        link <= 0;
        repeat (6) @(posedge clk);
        localOperands <= 32'h0F0E;
        step(4);
        chk(32'(teleIn1), 32'hA5C3);
        @(posedge clk);
        link <= 1;
        step(8);
        chk(32'(teleIn1), 32'h0F0E);
        chk(directOut, 32'h80000F0E);
        @(posedge clk);
        threeTerminal <= 0;
        twoChan <= 0;
        step(1);
        chk(32'(teleIn2), 32'h0);
        chk(32'(hybrid_permissive_receive), 32'h0F0E);
        @(posedge clk);
        twoChan <= 1;
        step(1);
        chk(32'(teleIn2), 32'h0FF1);
        @(posedge clk);
        teleEnable <= 0;
        step(1);
        chk(32'(teleIn1), 32'h0);
    endtask
    initial
    begin
        for (int i = 0; i < 32; i++)
            directOutSelect[i] = 7'(i);
        directOutSelect[31] = 7'h20;
        repeat (4) @(posedge clk);
        reset_n <= 1;
        t_fall;
        t_track;
        test_done;
    end
endmodule
`default_nettype wire
